// File: rtl/swc_sleep_wake_controller.sv
// Sleep entry, wake-up and resume sequencing for the processor core
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_wake_controller #(
	parameter int PC_W = 15,
	parameter int PORT_W = 8,
	parameter int WDT_CNT_W = 24,
	parameter int WDT_BASE_SHIFT = 5
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr_strobe,
	input wire logic i_rd_strobe,
	output logic [7:0] o_rdata,
	input wire logic i_sleep_instr,
	input wire logic i_clrwdt_instr,
	input wire logic [PC_W-1:0] i_pc,
	input wire logic i_global_irq_enable,
	input wire logic i_other_irq_pending,
	input wire logic [7:0] i_flag_set,
	input wire logic i_por_event,
	input wire logic i_brownout_reset,
	input wire logic i_brownout_enable,
	input wire logic i_external_reset_pin,
	input wire logic i_external_reset_enable,
	input wire logic [1:0] i_wdt_mode,
	input wire logic i_lf_tick,
	input wire logic i_adc_rc_selected,
	input wire logic [PORT_W-1:0] i_port_level,
	input wire logic [PORT_W-1:0] i_port_drive_en,
	output logic o_cpu_clock_enable,
	output logic o_asleep,
	output logic o_prefetch_strobe,
	output logic [PC_W-1:0] o_prefetch_addr,
	output logic o_sleep_as_nop,
	output logic o_resume_next,
	output logic o_isr_call,
	output logic [PC_W-1:0] o_isr_addr,
	output logic o_device_reset,
	output logic o_power_down_flag,
	output logic o_time_out_flag,
	output logic o_lf_osc_run,
	output logic o_timer_osc_run,
	output logic o_adc_clock_enable,
	output logic o_cap_sense_osc_run,
	output logic [PORT_W-1:0] o_port_level,
	output logic [PORT_W-1:0] o_port_drive_en
);
	import swc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		swc_state_type st;
		logic [7:0] enable;
		logic sw_wdt_en;
		logic [2:0] wdt_sel;
		logic power_down;
		logic to;
		logic [7:0] rdata;
		logic cpu_clk_en;
		logic asleep;
		logic prefetch;
		logic [PC_W-1:0] prefetch_addr;
		logic no_operation;
		logic resume;
		logic isr_call;
		logic [PC_W-1:0] isr_addr;
		logic dev_reset;
		logic wdt_clear;
		logic lf_run;
		logic t1_run;
		logic adc_en;
		logic cap_run;
		logic [PORT_W-1:0] port_level;
		logic [PORT_W-1:0] port_oe;
	} swc_top_state_type;

	localparam swc_top_state_type STATE_RESET = '{
		st: SWC_AWAKE,
		wdt_sel: WDT_SEL_RESET,
		power_down: 1'b1,
		to: 1'b1,
		cpu_clk_en: 1'b1,
		lf_run: 1'b1,
		t1_run: 1'b1,
		adc_en: 1'b1,
		cap_run: 1'b1,
		default: '0
	};

	swc_top_state_type state_q;
	swc_top_state_type state_d;
	logic reset_req;
	logic enabled_pending;
	logic wdt_active;
	logic wdt_timeout;
	logic wake_event;
	logic [WDT_CNT_W-1:0] wdt_limit;
	logic wr_flags;

	swc_flag_if flag_bus ();

	////////////////////////////////////////////////////////////////////////////////
	// Submodules

	swc_irq_flags u_flags (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.bus(flag_bus.owner)
	);

	swc_watchdog #(
		.CNT_W(WDT_CNT_W)
	) u_wdt (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_tick(i_lf_tick),
		.i_run(wdt_active),
		.i_clear(state_q.wdt_clear || i_clrwdt_instr),
		.i_limit(wdt_limit),
		.o_timeout(wdt_timeout)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode of events

	// Reset sources act the same in every state
	assign reset_req = i_por_event
		|| (i_brownout_reset && i_brownout_enable)
		|| (i_external_reset_pin && i_external_reset_enable);

	// Only individually enabled sources count, global enable ignored
	assign enabled_pending = (|(flag_bus.flags & state_q.enable & FLAG_IMPL_MASK))
		|| i_other_irq_pending;

	assign wake_event = enabled_pending || wdt_timeout;

	assign wr_flags = i_wr_strobe && (i_addr == FLAGS_OFS);
	assign flag_bus.wr_en = wr_flags;
	assign flag_bus.wr_data = i_wdata;
	assign flag_bus.set_req = i_flag_set & FLAG_IMPL_MASK;
	assign flag_bus.soft_clear = reset_req;

	assign wdt_limit = WDT_CNT_W'(1) << (32'(state_q.wdt_sel) + WDT_BASE_SHIFT);

	// Watchdog keeps counting in sleep only where its mode allows
	always_comb begin
		unique case (i_wdt_mode)
			WDT_MODE_ON: wdt_active = 1'b1;
			WDT_MODE_OFF_SLEEP: wdt_active = !state_q.asleep;
			WDT_MODE_SW: wdt_active = state_q.sw_wdt_en;
			default: wdt_active = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_d = state_q;
		state_d.rdata = 8'h00;
		state_d.prefetch = 1'b0;
		state_d.no_operation = 1'b0;
		state_d.resume = 1'b0;
		state_d.isr_call = 1'b0;
		state_d.dev_reset = 1'b0;
		state_d.wdt_clear = 1'b0;
		state_d.lf_run = 1'b1;
		state_d.t1_run = 1'b1;
		state_d.cap_run = 1'b1;
		state_d.adc_en = !state_q.asleep || i_adc_rc_selected;

		// Pins follow the core while awake and freeze in sleep
		if (!state_q.asleep) begin
			state_d.port_level = i_port_level;
			state_d.port_oe = i_port_drive_en;
		end

		// Register writes
		if (i_wr_strobe) begin
			if (i_addr == ENABLE_OFS) begin
				state_d.enable = i_wdata & FLAG_IMPL_MASK;
			end else if (i_addr == CTRL_OFS) begin
				state_d.sw_wdt_en = i_wdata[CTRL_SW_WDT_BIT];
				state_d.wdt_sel = i_wdata[CTRL_SEL_LSB+:3];
			end
		end

		// Register reads, answered in the next cycle only
		if (i_rd_strobe) begin
			unique case (i_addr)
				FLAGS_OFS: state_d.rdata = flag_bus.flags;
				ENABLE_OFS: state_d.rdata = state_q.enable;
				CTRL_OFS: state_d.rdata = {4'h0, state_q.wdt_sel, state_q.sw_wdt_en};
				STATUS_OFS: begin
					state_d.rdata[TIME_OUT_BIT] = state_q.to;
					state_d.rdata[POWER_DOWN_BIT] = state_q.power_down;
				end
				default: state_d.rdata = 8'h00;
			endcase
		end

		unique case (state_q.st)
			SWC_AWAKE: begin
				if (i_sleep_instr) begin
					state_d.prefetch = 1'b1;
					state_d.prefetch_addr = i_pc + PC_W'(1);
					if (enabled_pending) begin
						// Sleep degrades to a no-operation
						state_d.no_operation = 1'b1;
					end else begin
						state_d.st = SWC_ASLEEP;
						state_d.power_down = 1'b0;
						state_d.to = 1'b1;
						state_d.wdt_clear = 1'b1;
						state_d.cpu_clk_en = 1'b0;
						state_d.asleep = 1'b1;
					end
				end else if (wdt_timeout) begin
					// Watchdog expiry while awake resets the device
					state_d.dev_reset = 1'b1;
					state_d.to = 1'b0;
				end
			end
			SWC_ASLEEP: begin
				if (wake_event) begin
					if (wdt_timeout) begin
						state_d.to = 1'b0;
					end
					state_d.st = SWC_WAKING;
					state_d.wdt_clear = 1'b1;
					state_d.cpu_clk_en = 1'b1;
					state_d.asleep = 1'b0;
				end
			end
			SWC_WAKING: begin
				// Instruction after sleep runs in every case
				state_d.resume = 1'b1;
				state_d.st = i_global_irq_enable ? SWC_CALL : SWC_AWAKE;
			end
			SWC_CALL: begin
				state_d.isr_call = 1'b1;
				state_d.isr_addr = ISR_VECTOR[PC_W-1:0];
				state_d.st = SWC_AWAKE;
			end
		endcase

		// Reset sources win over everything else
		if (reset_req) begin
			state_d = STATE_RESET;
			state_d.dev_reset = 1'b1;
			state_d.wdt_clear = 1'b1;
			state_d.port_level = i_port_level;
			state_d.port_oe = i_port_drive_en;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata = state_q.rdata;
	assign o_cpu_clock_enable = state_q.cpu_clk_en;
	assign o_asleep = state_q.asleep;
	assign o_prefetch_strobe = state_q.prefetch;
	assign o_prefetch_addr = state_q.prefetch_addr;
	assign o_sleep_as_nop = state_q.no_operation;
	assign o_resume_next = state_q.resume;
	assign o_isr_call = state_q.isr_call;
	assign o_isr_addr = state_q.isr_addr;
	assign o_device_reset = state_q.dev_reset;
	assign o_power_down_flag = state_q.power_down;
	assign o_time_out_flag = state_q.to;
	assign o_lf_osc_run = state_q.lf_run;
	assign o_timer_osc_run = state_q.t1_run;
	assign o_adc_clock_enable = state_q.adc_en;
	assign o_cap_sense_osc_run = state_q.cap_run;
	assign o_port_level = state_q.port_level;
	assign o_port_drive_en = state_q.port_oe;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_SLEEP_ENTRY: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_AWAKE && i_sleep_instr && !enabled_pending && !reset_req)
		|=> (!o_power_down_flag && o_time_out_flag && o_asleep && !o_cpu_clock_enable))
		else $error("sleep entry did not update status");

	AST_SLEEP_NOP: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_AWAKE && i_sleep_instr && enabled_pending && !reset_req)
		|=> (o_sleep_as_nop && !o_asleep && $stable(o_power_down_flag)
		&& $stable(o_time_out_flag) && !state_q.wdt_clear))
		else $error("pending flag did not turn sleep into a no-operation");

	AST_CLOCK_STOPPED: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_asleep |-> !o_cpu_clock_enable)
		else $error("processor clock running in sleep");

	AST_CLOCK_BEFORE_RESUME: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_ASLEEP && wake_event && !reset_req)
		|=> o_cpu_clock_enable && !o_resume_next ##1 o_resume_next)
		else $error("resume without clock re-enabled first");

	AST_WDT_CLEAR_ON_WAKE: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_ASLEEP && wake_event) |=> state_q.wdt_clear)
		else $error("watchdog not cleared on wake");

	AST_GLOBAL_ON_CALL: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_WAKING && i_global_irq_enable && !reset_req)
		|=> o_resume_next ##1 (o_isr_call && o_isr_addr == ISR_VECTOR[PC_W-1:0]))
		else $error("service call missing after wake");

	AST_GLOBAL_OFF_INLINE: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_WAKING && !i_global_irq_enable && !reset_req)
		|=> o_resume_next ##1 !o_isr_call)
		else $error("service called with global enable clear");

	AST_RESET_WAKE: assert property (@(posedge i_clock) disable iff (!i_resetn)
		reset_req |=> (o_device_reset && !o_asleep && o_cpu_clock_enable))
		else $error("reset source did not reset device");

	AST_PREFETCH: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q.st == SWC_AWAKE && i_sleep_instr && !reset_req)
		|=> (o_prefetch_strobe && o_prefetch_addr == $past(i_pc) + PC_W'(1)))
		else $error("next address not prefetched");

	AST_PORT_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_asleep && $past(o_asleep)) |-> ($stable(o_port_level) && $stable(o_port_drive_en)))
		else $error("port state moved in sleep");

	AST_OSC_RUN: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_asleep |-> (o_lf_osc_run && o_timer_osc_run && o_cap_sense_osc_run))
		else $error("oscillator stopped in sleep");
endmodule
`default_nettype wire

// File: rtl/swc_pkg.sv
// Constants, types and register map of the sleep and wake controller
package swc_pkg;
	localparam logic [7:0] FLAGS_OFS = 8'h00;
	localparam logic [7:0] ENABLE_OFS = 8'h01;
	localparam logic [7:0] CTRL_OFS = 8'h02;
	localparam logic [7:0] STATUS_OFS = 8'h03;
	localparam int CAPCOMP_FIVE_BIT = 6;
	localparam int CAPCOMP_FOUR_BIT = 5;
	localparam int CAPCOMP_THREE_BIT = 4;
	localparam int TIMER_SIX_BIT = 3;
	localparam int TIMER_FOUR_BIT = 1;
	localparam logic [7:0] FLAG_IMPL_MASK = 8'h7A;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam int TIME_OUT_BIT = 4;
	localparam int POWER_DOWN_BIT = 3;
	localparam int CTRL_SW_WDT_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam logic [2:0] WDT_SEL_RESET = 3'h5;
	localparam logic [1:0] WDT_MODE_ON = 2'h3;
	localparam logic [1:0] WDT_MODE_OFF_SLEEP = 2'h2;
	localparam logic [1:0] WDT_MODE_SW = 2'h1;
	localparam logic [15:0] ISR_VECTOR = 16'h0004;
	typedef enum logic [2:0] {SWC_AWAKE, SWC_ASLEEP, SWC_WAKING, SWC_CALL} swc_state_type;
endpackage

// File: rtl/swc_flag_if.sv
// Carrier between the controller and its interrupt flag register
`timescale 1ns/1ps
`default_nettype none
interface swc_flag_if;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] set_req;
	logic soft_clear;
	logic [7:0] flags;
	modport owner (input wr_en, input wr_data, input set_req, input soft_clear, output flags);
	modport user (output wr_en, output wr_data, output set_req, output soft_clear, input flags);
endinterface
`default_nettype wire

// File: rtl/swc_irq_flags.sv
// Third peripheral interrupt flag register
`timescale 1ns/1ps
`default_nettype none
module swc_irq_flags (
	input wire logic i_clock,
	input wire logic i_resetn,
	swc_flag_if.owner bus
);
	import swc_pkg::*;
	typedef struct packed {
		logic [7:0] flags;
	} swc_flag_state_type;
	swc_flag_state_type state_q;
	swc_flag_state_type state_d;
	always_comb begin
		state_d = state_q;
		if (bus.soft_clear) begin
			state_d.flags = FLAG_RESET;
		end else begin
			if (bus.wr_en) begin
				state_d.flags = bus.wr_data;
			end
			state_d.flags = state_d.flags | bus.set_req;
		end
		state_d.flags = state_d.flags & FLAG_IMPL_MASK;
	end
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end
	assign bus.flags = state_q.flags;
	AST_FLAG_SET_WINS: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(bus.set_req[CAPCOMP_FIVE_BIT] && !bus.soft_clear) |=> bus.flags[CAPCOMP_FIVE_BIT])
		else $error("flag set lost");
	AST_UNIMPL_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(bus.flags & ~FLAG_IMPL_MASK) == 8'h00)
		else $error("unimplemented flag bit set");
endmodule
`default_nettype wire

// File: rtl/swc_watchdog.sv
// Watchdog counter on the low-frequency tick
`timescale 1ns/1ps
`default_nettype none
module swc_watchdog #(
	parameter int CNT_W = 24
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic i_clear,
	input wire logic [CNT_W-1:0] i_limit,
	output logic o_timeout
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic timeout;
	} swc_wdt_state_type;
	swc_wdt_state_type state_q;
	swc_wdt_state_type state_d;
	always_comb begin
		state_d = state_q;
		state_d.timeout = 1'b0;
		if (i_clear || !i_run) begin
			state_d.count = '0;
		end else if (i_tick) begin
			if (state_q.count >= i_limit) begin
				state_d.count = '0;
				state_d.timeout = 1'b1;
			end else begin
				state_d.count = state_q.count + CNT_W'(1);
			end
		end
	end
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end
	assign o_timeout = state_q.timeout;
endmodule
`default_nettype wire

// File: dv/swc_core_model.sv
// Processor core model that issues sleep and advances its program counter
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_cpu_clock_enable,
	input wire logic i_cmd_sleep,
	output logic o_sleep_instr,
	output logic [14:0] o_pc
);
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pc <= 15'h0100;
			o_sleep_instr <= 1'b0;
		end else begin
			// Sleep only as an executed instruction
			o_sleep_instr <= i_cmd_sleep && i_cpu_clock_enable;
			// Slot after sleep holds a no-operation
			if (i_cpu_clock_enable && !o_sleep_instr) begin
				o_pc <= o_pc + 15'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/swc_sleep_wake_controller_tb.sv
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_wake_controller_tb;
	import swc_pkg::*;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr_strobe = 1'b0;
	logic i_rd_strobe = 1'b0;
	logic i_clrwdt_instr = 1'b0;
	logic i_global_irq_enable = 1'b0;
	logic i_other_irq_pending = 1'b0;
	logic [7:0] i_flag_set = 8'h00;
	logic i_por_event = 1'b0;
	logic i_brownout_reset = 1'b0;
	logic i_brownout_enable = 1'b1;
	logic i_external_reset_pin = 1'b0;
	logic i_external_reset_enable = 1'b0;
	logic [1:0] i_wdt_mode = 2'h0;
	logic i_lf_tick = 1'b0;
	logic i_adc_rc_selected = 1'b1;
	logic [7:0] i_port_level = 8'h00;
	logic [7:0] i_port_drive_en = 8'h00;
	logic cmd_sleep = 1'b0;
	logic sleep_instr, o_cpu_clock_enable, o_asleep, o_prefetch_strobe, o_sleep_as_nop;
	logic o_resume_next, o_isr_call, o_device_reset, o_power_down_flag, o_time_out_flag;
	logic o_lf_osc_run, o_timer_osc_run, o_adc_clock_enable, o_cap_sense_osc_run;
	logic [14:0] pc, o_prefetch_addr, o_isr_addr;
	logic [7:0] o_rdata, o_port_level, o_port_drive_en;
	logic rd_d = 1'b0;
	logic [7:0] rd_q[$];
	logic [14:0] pf_q[$];
	int n_errors = 0;
	int num_checks = 0;
	int n_nop = 0, n_res = 0, n_isr = 0, n_rst = 0, cyc = 0;

	swc_sleep_wake_controller #(.WDT_BASE_SHIFT(0)) dut_u (.i_clock, .i_resetn, .i_addr,
		.i_wdata, .i_wr_strobe, .i_rd_strobe, .o_rdata, .i_sleep_instr(sleep_instr),
		.i_clrwdt_instr, .i_pc(pc), .i_global_irq_enable, .i_other_irq_pending, .i_flag_set,
		.i_por_event, .i_brownout_reset, .i_brownout_enable, .i_external_reset_pin,
		.i_external_reset_enable, .i_wdt_mode, .i_lf_tick, .i_adc_rc_selected, .i_port_level,
		.i_port_drive_en, .o_cpu_clock_enable, .o_asleep, .o_prefetch_strobe, .o_prefetch_addr,
		.o_sleep_as_nop, .o_resume_next, .o_isr_call, .o_isr_addr, .o_device_reset,
		.o_power_down_flag, .o_time_out_flag, .o_lf_osc_run, .o_timer_osc_run,
		.o_adc_clock_enable, .o_cap_sense_osc_run, .o_port_level, .o_port_drive_en);
	swc_core_model core_u (.i_clock, .i_resetn, .i_cpu_clock_enable(o_cpu_clock_enable),
		.i_cmd_sleep(cmd_sleep), .o_sleep_instr(sleep_instr), .o_pc(pc));

	always #10 i_clock = ~i_clock;

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected byte at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkw(input logic [14:0] got, input logic [14:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected address at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			n_errors++;
			$display("unexpected count at %0t: got %0d want %0d", $time, got, exp);
		end
	endtask

	// Scoreboard side: result watcher
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		i_lf_tick <= (cyc % 4 == 3);
		rd_d <= i_rd_strobe;
		if (rd_d) chk8(o_rdata, rd_q.pop_front());
		if (sleep_instr) pf_q.push_back(pc + 15'h0001);
		if (o_prefetch_strobe) chkw(o_prefetch_addr, pf_q.pop_front());
		if (o_sleep_as_nop) n_nop++;
		if (o_resume_next) n_res++;
		if (o_device_reset) n_rst++;
		if (o_isr_call) begin
			n_isr++;
			chkw(o_isr_addr, ISR_VECTOR[14:0]);
		end
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr_strobe <= 1'b1;
		@(posedge i_clock);
		i_wr_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_addr <= a;
		i_rd_strobe <= 1'b1;
		rd_q.push_back(exp);
		@(posedge i_clock);
		i_rd_strobe <= 1'b0;
	endtask
	task automatic pulse(input int b);
		@(posedge i_clock);
		i_flag_set <= 8'h01 << b;
		@(posedge i_clock);
		i_flag_set <= 8'h00;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		@(negedge i_clock);
	endtask
	task automatic do_sleep(input logic [1:0] m);
		@(posedge i_clock);
		cmd_sleep <= 1'b1;
		@(posedge i_clock);
		cmd_sleep <= 1'b0;
		i_wdt_mode <= m;
		settle(3);
	endtask
	task automatic wait_wake();
		for (int i = 0; i < 300 && o_asleep !== 1'b0; i++) @(negedge i_clock);
		chk8({7'h00, o_asleep}, 8'h00);
	endtask
	function automatic logic [7:0] st(input logic p, input logic t);
		st = 8'h00;
		st[POWER_DOWN_BIT] = p;
		st[TIME_OUT_BIT] = t;
	endfunction

	initial begin
		logic [7:0] r, lv, en;
		logic [14:0] pc0;
		int b0, b1;
		void'($urandom(44798));
		repeat (8) @(posedge i_clock);
		i_resetn <= 1'b1;
		rd(FLAGS_OFS, FLAG_RESET);
		rd(STATUS_OFS, st(1'b1, 1'b1));
		rd(CTRL_OFS, {4'h0, WDT_SEL_RESET, 1'b0});
		rd(8'hF0, 8'h00);
		wr(FLAGS_OFS, 8'hFF);
		rd(FLAGS_OFS, FLAG_IMPL_MASK);
		r = 8'($urandom);
		wr(ENABLE_OFS, r);
		rd(ENABLE_OFS, r & FLAG_IMPL_MASK);
		wr(ENABLE_OFS, 8'h00);
		wr(FLAGS_OFS, 8'h00);
		for (int b = 0; b < 8; b++) begin
			pulse(b);
			rd(FLAGS_OFS, (8'h01 << b) & FLAG_IMPL_MASK);
			wr(FLAGS_OFS, 8'h00);
		end
		// Sleep with a wake source already pending
		wr(ENABLE_OFS, 8'h01 << TIMER_SIX_BIT);
		pulse(TIMER_SIX_BIT);
		do_sleep(2'h0);
		chkn(n_nop, 1);
		chk8({7'h00, o_asleep}, 8'h00);
		rd(STATUS_OFS, st(1'b1, 1'b1));
		wr(FLAGS_OFS, 8'h00);
		i_other_irq_pending <= 1'b1;
		do_sleep(2'h0);
		chkn(n_nop, 2);
		@(posedge i_clock);
		i_other_irq_pending <= 1'b0;
		// Interrupt wake with global enable clear, then set
		for (int g = 0; g < 2; g++) begin
			@(posedge i_clock);
			lv = 8'($urandom);
			en = 8'($urandom);
			i_port_level <= lv;
			i_port_drive_en <= en;
			i_global_irq_enable <= g[0];
			i_adc_rc_selected <= g[0];
			do_sleep(2'h0);
			chk8({7'h00, o_cpu_clock_enable}, 8'h00);
			chk8({6'h00, o_power_down_flag, o_time_out_flag}, 8'h01);
			rd(STATUS_OFS, st(1'b0, 1'b1));
			pc0 = pc;
			i_port_level <= ~lv;
			i_port_drive_en <= ~en;
			pulse(CAPCOMP_FIVE_BIT);
			settle(4);
			chk8(o_port_level, lv);
			chk8(o_port_drive_en, en);
			chkw(pc, pc0);
			chk8({7'h00, o_asleep}, 8'h01);
			chk8({4'h0, o_lf_osc_run, o_timer_osc_run, o_cap_sense_osc_run, o_adc_clock_enable},
				{7'h07, g[0]});
			b0 = n_res;
			b1 = n_isr;
			pulse(TIMER_SIX_BIT);
			wait_wake();
			chk8({7'h00, o_cpu_clock_enable}, 8'h01);
			settle(4);
			chkn(n_res - b0, 1);
			chkn(n_isr - b1, g);
			wr(FLAGS_OFS, 8'h00);
		end
		// Watchdog wake continues execution
		i_global_irq_enable <= 1'b0;
		wr(CTRL_OFS, 8'h00);
		b0 = n_res;
		b1 = n_rst;
		do_sleep(WDT_MODE_ON);
		wait_wake();
		@(posedge i_clock);
		i_wdt_mode <= 2'h0;
		rd(STATUS_OFS, st(1'b0, 1'b0));
		settle(2);
		chkn(n_res - b0, 1);
		chkn(n_rst - b1, 0);
		// Watchdog off in sleep, disabled pin reset, then brown-out
		do_sleep(WDT_MODE_OFF_SLEEP);
		@(posedge i_clock);
		i_external_reset_pin <= 1'b1;
		@(posedge i_clock);
		i_external_reset_pin <= 1'b0;
		settle(20);
		chk8({7'h00, o_asleep}, 8'h01);
		pulse(CAPCOMP_THREE_BIT);
		b1 = n_rst;
		@(posedge i_clock);
		i_brownout_reset <= 1'b1;
		i_wdt_mode <= 2'h0;
		@(posedge i_clock);
		i_brownout_reset <= 1'b0;
		settle(3);
		chkn(n_rst - b1, 1);
		chk8({7'h00, o_asleep}, 8'h00);
		rd(FLAGS_OFS, 8'h00);
		// Enabled pin reset while awake clears the flags as well
		pulse(CAPCOMP_FOUR_BIT);
		b1 = n_rst;
		@(posedge i_clock);
		i_external_reset_enable <= 1'b1;
		i_external_reset_pin <= 1'b1;
		@(posedge i_clock);
		i_external_reset_pin <= 1'b0;
		settle(3);
		chkn(n_rst - b1, 1);
		rd(FLAGS_OFS, 8'h00);
		settle(3);
		end_sim();
	end
endmodule
`default_nettype wire
